// [bench/tec_ctrl_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// port checker
module tec_ctrl_checker (
  input wire logic       sys_clk_i, rst_i, sfr_wr_i, sfr_rd_i, bit_rd_i, bit_wr_i,
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, bit_addr_i,
  input wire logic       bit_rdata_o, t0_ovf_i, t1_ovf_i, t0_vec_ack_i, t1_vec_ack_i,
  input wire logic       t0_pin_gating_bit_i, t1_pin_gating_bit_i, t0_run_o, t1_run_o,
  input wire logic       t0_count_en_o, t1_count_en_o,
  input wire logic [3:0] irq_pend_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // a write may move a flag too, so ack checks skip those cycles
  wire bw_w     = sfr_wr_i && sfr_addr_i == 8'h88;
  wire hit_w    = bw_w || bit_wr_i;
  wire t1_clr_w = t1_vec_ack_i && !t1_ovf_i && !hit_w;
  wire t0_clr_w = t0_vec_ack_i && !t0_ovf_i && !hit_w;
  wire br_w     = sfr_rd_i && sfr_addr_i == 8'h88;
  wire bu_w     = bit_rd_i && bit_addr_i[7:3] != 5'h11;
  t1_pend_set_a: assert property (t1_ovf_i |-> ##2 irq_pend_o[1])
    else $error("t1 overflow not pending");
  t0_pend_set_a: assert property (t0_ovf_i |-> ##2 irq_pend_o[0])
    else $error("t0 overflow not pending");
  t1_ack_clr_a: assert property (t1_clr_w |-> ##2 !irq_pend_o[1])
    else $error("t1 flag kept after ack");
  t0_ack_clr_a: assert property (t0_clr_w |-> ##2 !irq_pend_o[0])
    else $error("t0 flag kept after ack");
  run_write_a: assert property (bw_w |-> ##2
    t1_run_o == $past(sfr_wdata_i[6], 2) && t0_run_o == $past(sfr_wdata_i[4], 2))
    else $error("run outputs miss write");
  stop_count_a: assert property (!t1_run_o |-> !t1_count_en_o)
    else $error("t1 counts while stopped");
  gate_off_count_a: assert property (t0_run_o && !$past(t0_pin_gating_bit_i)
    |-> t0_count_en_o) else $error("t0 not counting");
  byte_rd_idle_a: assert property (!br_w |=> sfr_rdata_o == 8'h00)
    else $error("byte read data not zero");
  bit_rd_unmap_a: assert property (bu_w |=> !bit_rdata_o)
    else $error("bit read data not zero");
  cover property (t1_ovf_i ##2 irq_pend_o[1]);
  cover property (t0_vec_ack_i);
  cover property (t1_count_en_o && t1_pin_gating_bit_i);
  cover property (irq_pend_o[3] && t1_pin_gating_bit_i);
endmodule // tec_ctrl_checker
`default_nettype wire

// [bench/tec_irq_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// interrupt controller: acks each enabled pending request
module tec_irq_ctrl_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] pend_i,
  input  wire logic [3:0] auto_i,
  output logic      [3:0] ack_o
);
  logic [3:0] hold_r;
  // pending lags the flag, so a hold-off cycle avoids a double ack
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_o  <= 4'h0;
      hold_r <= 4'h0;
    end else begin
      ack_o  <= pend_i & auto_i & ~ack_o & ~hold_r;
      hold_r <= ack_o;
    end
  end
endmodule // tec_irq_ctrl_model
`default_nettype wire

// [bench/tec_timer_extint_ctrl_test.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// bench
module tec_timer_extint_ctrl_test;
  logic       sys_clk_i = 1'h0, rst_i = 1'h1, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
  logic       bit_wr_i = 1'h0, bit_rd_i = 1'h0, bit_wdata_i = 1'h0;
  logic       t0_ovf_i = 1'h0, t1_ovf_i = 1'h0, ext_irq_pin_a_i = 1'h1, ext_irq_pin_b_i = 1'h1;
  logic       t0_pin_gating_bit_i = 1'h0, t1_pin_gating_bit_i = 1'h0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, bit_addr_i = 8'h00, img, a;
  logic [3:0] auto_r = 4'h0;
  wire  [3:0] ack_w, irq_pend_o;
  wire  [7:0] sfr_rdata_o;
  wire        bit_rdata_o, t0_run_o, t1_run_o, t0_count_en_o, t1_count_en_o;
  int         err_total = 0, samples_checked = 0, cyc = 0, i, k;

  tec_timer_extint_ctrl dut_u (.sys_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_rd_i, .sfr_rdata_o, .bit_addr_i, .bit_wr_i, .bit_wdata_i, .bit_rd_i, .bit_rdata_o,
    .t0_ovf_i, .t1_ovf_i, .t0_pin_gating_bit_i, .t1_pin_gating_bit_i, .ext_irq_pin_a_i,
    .ext_irq_pin_b_i, .t0_vec_ack_i(ack_w[0]), .t1_vec_ack_i(ack_w[1]),
    .x0_vec_ack_i(ack_w[2]), .x1_vec_ack_i(ack_w[3]), .t0_run_o, .t1_run_o,
    .t0_count_en_o, .t1_count_en_o, .irq_pend_o);
  tec_irq_ctrl_model ctl_u (.sys_clk_i, .rst_i, .pend_i(irq_pend_o), .auto_i(auto_r),
    .ack_o(ack_w));

  always #50 sys_clk_i = ~sys_clk_i;
  // hang guard, well above the length of the sequence
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // one bus cycle: bt picks bit access, wt picks write; read data is settled on return
  task automatic acc(input logic bt, wt, input logic [7:0] ad, d);
    @(posedge sys_clk_i);
    sfr_addr_i  <= ad;
    bit_addr_i  <= ad;
    sfr_wdata_i <= d;
    bit_wdata_i <= d[0];
    {sfr_wr_i, bit_wr_i, sfr_rd_i, bit_rd_i} <= {wt & ~bt, wt & bt, ~wt & ~bt, ~wt & bt};
    @(posedge sys_clk_i);
    {sfr_wr_i, bit_wr_i, sfr_rd_i, bit_rd_i} <= 4'h0;
    #1;
  endtask
  // level-mode flags follow the idle-high pins; the old mode governs the write cycle
  function automatic logic [7:0] nx(input logic [7:0] o, d);
    nx = {d[7:4], o[2] & d[2] & d[3], d[2], o[0] & d[0] & d[1], d[0]};
  endfunction

  initial begin
    void'($urandom(32'h38AA1A27));
    tick(6);
    rst_i <= 1'h0;
    acc(1'h0, 1'h0, 8'h88, 8'h00);
    chk8(sfr_rdata_o, 8'h00);
    img = 8'h00;
    for (i = 0; i < 30; i++) begin
      k = $urandom;
      @(posedge sys_clk_i);
      {t1_pin_gating_bit_i, t0_pin_gating_bit_i} <= k[21:20];
      a = k[9] ? 8'h88 : 8'h88 | k[2:0];
      if (k[12:11] == 2'h0) a = 8'h80 | k[2:0];
      acc(~k[9], 1'h1, a, k[9] ? k[7:0] : {7'h0, k[3]});
      if (a[3]) img = nx(img, k[9] ? k[7:0] : (img & ~(8'h01 << k[2:0])) | (k[3] << k[2:0]));
      acc(1'h0, 1'h0, 8'h88, 8'h00);
      chk8(sfr_rdata_o, img);
      acc(1'h1, 1'h0, 8'h88 | k[18:16], 8'h00);
      chk1(bit_rdata_o, img[k[18:16]]);
      chk1(t1_count_en_o, img[6]);
      chk1(t0_count_en_o, img[4]);
    end
    acc(1'h0, 1'h0, 8'h89, 8'h00);
    chk8(sfr_rdata_o, 8'h00);
    acc(1'h1, 1'h0, 8'h87, 8'h00);
    chk1(bit_rdata_o, 1'h0);
    acc(1'h0, 1'h1, 8'h88, 8'h00);
    for (i = 0; i < 2; i++) begin
      a = i ? 8'h8F : 8'h8D;
      @(posedge sys_clk_i);
      {t1_ovf_i, t0_ovf_i} <= i ? 2'h2 : 2'h1;
      @(posedge sys_clk_i);
      {t1_ovf_i, t0_ovf_i} <= 2'h0;
      acc(1'h1, 1'h0, a, 8'h00);
      chk1(bit_rdata_o, 1'h1);
      auto_r <= 4'h3;
      tick(8);
      acc(1'h1, 1'h0, a, 8'h00);
      chk1(bit_rdata_o, 1'h0);
      auto_r <= 4'h0;
    end
    @(posedge sys_clk_i);
    {t1_pin_gating_bit_i, t0_pin_gating_bit_i} <= 2'h3;
    for (i = 0; i < 4; i++) begin
      a = i[0] ? 8'h8B : 8'h89;
      acc(1'h0, 1'h1, 8'h88, i[1] ? 8'h55 : 8'h50);
      // pins change on a rising edge so the filter delay is exact
      @(posedge sys_clk_i);
      {ext_irq_pin_b_i, ext_irq_pin_a_i} <= i[0] ? 2'h1 : 2'h2;
      tick(6);
      acc(1'h1, 1'h0, a, 8'h00);
      chk1(bit_rdata_o, 1'h1);
      chk1(i[0] ? t1_count_en_o : t0_count_en_o, 1'h0);
      auto_r <= 4'hC;
      tick(8);
      acc(1'h1, 1'h0, a, 8'h00);
      chk1(bit_rdata_o, ~i[1]);
      @(posedge sys_clk_i);
      {ext_irq_pin_b_i, ext_irq_pin_a_i} <= 2'h3;
      tick(6);
      acc(1'h1, 1'h0, a, 8'h00);
      chk1(bit_rdata_o, 1'h0);
      chk1(i[0] ? t1_count_en_o : t0_count_en_o, 1'h1);
      auto_r <= 4'h0;
    end
    end_of_test();
  end
endmodule // tec_timer_extint_ctrl_test

bind tec_timer_extint_ctrl tec_ctrl_checker chk_u (.sys_clk_i, .rst_i, .sfr_wr_i, .sfr_rd_i,
  .bit_rd_i, .bit_wr_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .bit_addr_i, .bit_rdata_o,
  .t0_ovf_i, .t1_ovf_i, .t0_vec_ack_i, .t1_vec_ack_i, .t0_pin_gating_bit_i,
  .t1_pin_gating_bit_i, .t0_run_o, .t1_run_o, .t0_count_en_o, .t1_count_en_o, .irq_pend_o);
`default_nettype wire

// [hdl/tec_defines.vh]
`ifndef TEC_DEFINES_VH
`define TEC_DEFINES_VH

// ====================================================================
// register placement
// byte address of the control register in the special function space
`define TEC_SFR_ADDR        8'h88
// bit address of bit 0; bits 1..7 follow at consecutive addresses
`define TEC_BIT_BASE        8'h88
`define TEC_RESET_VAL       8'h00

// ====================================================================
// field positions
`define TEC_T1_OVF_POS      3'h7
`define TEC_T1_RUN_POS      3'h6
`define TEC_T0_OVF_POS      3'h5
`define TEC_T0_RUN_POS      3'h4
`define TEC_X1_FLAG_POS     3'h3
`define TEC_X1_TYPE_POS     3'h2
`define TEC_X0_FLAG_POS     3'h1
`define TEC_X0_TYPE_POS     3'h0

// ====================================================================
// pending request vector layout
`define TEC_PEND_T0         2'h0
`define TEC_PEND_T1         2'h1
`define TEC_PEND_X0         2'h2
`define TEC_PEND_X1         2'h3

// ====================================================================
// pin conditioning
// idle level of the external request pins after reset
`define TEC_PIN_IDLE        1'h1

`endif

// [hdl/tec_timer_extint_ctrl.v]
`timescale 1ns/100ps
`default_nettype none

`include "tec_defines.vh"

module tec_timer_extint_ctrl (
  input  wire       sys_clk_i,
  input  wire       rst_i,
  // byte access from the core
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire [7:0] sfr_wdata_i,
  input  wire       sfr_rd_i,
  output reg  [7:0] sfr_rdata_o,
  // single-bit access from the core
  input  wire [7:0] bit_addr_i,
  input  wire       bit_wr_i,
  input  wire       bit_wdata_i,
  input  wire       bit_rd_i,
  output reg        bit_rdata_o,
  // overflow strobes from the timer counters
  input  wire       t0_ovf_i,
  input  wire       t1_ovf_i,
  // gating bits held in the timer mode register
  input  wire       t0_pin_gating_bit_i,
  input  wire       t1_pin_gating_bit_i,
  // external request pins, asynchronous
  input  wire       ext_irq_pin_a_i,
  input  wire       ext_irq_pin_b_i,
  // vector acknowledges from the interrupt controller
  input  wire       t0_vec_ack_i,
  input  wire       t1_vec_ack_i,
  input  wire       x0_vec_ack_i,
  input  wire       x1_vec_ack_i,
  // to timers and interrupt controller
  output reg        t0_run_o,
  output reg        t1_run_o,
  output reg        t0_count_en_o,
  output reg        t1_count_en_o,
  output reg  [3:0] irq_pend_o
);

  // ==================================================================
  // helpers
  // true when a bit address selects field idx of this register
  function bit_hit;
    input [7:0] addr;
    input [2:0] idx;
    begin
      bit_hit = (addr == (`TEC_BIT_BASE | {5'h00, idx}));
    end
  endfunction

  // request flag update shared by both external pins
  function req_next;
    input edge_mode;
    input cur;
    input fall;
    input ack;
    input wen;
    input wval;
    input pin_lvl;
    begin
      if (!edge_mode) begin
        req_next = ~pin_lvl;
      end else if (fall) begin
        req_next = 1'h1;
      end else if (wen) begin
        req_next = wval;
      end else if (ack) begin
        req_next = 1'h0;
      end else begin
        req_next = cur;
      end
    end
  endfunction

  // ==================================================================
  // state
  reg       t1_overflow_flag_r;
  reg       t1_run_bit_r;
  reg       t0_overflow_flag_r;
  reg       t0_run_bit_r;
  reg       ext_req1_flag_r;
  reg       ext_req1_trigger_type_r;
  reg       ext_req0_flag_r;
  reg       ext_req0_trigger_type_r;
  reg [2:0] pin_a_sync_r;
  reg [2:0] pin_b_sync_r;
  reg       pin_a_lvl_r;
  reg       pin_b_lvl_r;
  reg       pin_a_prev_r;
  reg       pin_b_prev_r;

  reg       t1_overflow_flag_nxt;
  reg       t1_run_bit_nxt;
  reg       t0_overflow_flag_nxt;
  reg       t0_run_bit_nxt;
  reg       ext_req1_flag_nxt;
  reg       ext_req1_trigger_type_nxt;
  reg       ext_req0_flag_nxt;
  reg       ext_req0_trigger_type_nxt;
  reg [7:0] wr_mask;
  reg [7:0] wr_val;

  // reset image of the whole byte; each bit takes its own field from it
  localparam [7:0] reset_image = `TEC_RESET_VAL;

  wire [7:0] timer_and_extint_control;
  wire       pin_a_fall;
  wire       pin_b_fall;

  // assembled register image
  assign timer_and_extint_control = {t1_overflow_flag_r, t1_run_bit_r,
                                     t0_overflow_flag_r, t0_run_bit_r,
                                     ext_req1_flag_r, ext_req1_trigger_type_r,
                                     ext_req0_flag_r, ext_req0_trigger_type_r};

  // falling edges of the filtered pin levels
  assign pin_a_fall = pin_a_prev_r & ~pin_a_lvl_r;
  assign pin_b_fall = pin_b_prev_r & ~pin_b_lvl_r;

  // ==================================================================
  // pin conditioning
  // three stages; the level moves only once stages two and three agree,
  // which rejects a single-cycle glitch at the cost of two cycles latency
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_a_sync_r <= {3{`TEC_PIN_IDLE}};
      pin_b_sync_r <= {3{`TEC_PIN_IDLE}};
      pin_a_lvl_r  <= `TEC_PIN_IDLE;
      pin_b_lvl_r  <= `TEC_PIN_IDLE;
      pin_a_prev_r <= `TEC_PIN_IDLE;
      pin_b_prev_r <= `TEC_PIN_IDLE;
    end else begin
      pin_a_sync_r <= {pin_a_sync_r[1:0], ext_irq_pin_a_i};
      pin_b_sync_r <= {pin_b_sync_r[1:0], ext_irq_pin_b_i};
      if (pin_a_sync_r[1] == pin_a_sync_r[2]) begin
        pin_a_lvl_r <= pin_a_sync_r[2];
      end
      if (pin_b_sync_r[1] == pin_b_sync_r[2]) begin
        pin_b_lvl_r <= pin_b_sync_r[2];
      end
      pin_a_prev_r <= pin_a_lvl_r;
      pin_b_prev_r <= pin_b_lvl_r;
    end
  end

  // ==================================================================
  // software write decode
  // a byte write touches every bit, a bit write at most one, the bit its address selects
  always @* begin
    wr_mask = 8'h00;
    wr_val  = 8'h00;
    if (sfr_wr_i && (sfr_addr_i == `TEC_SFR_ADDR)) begin
      wr_mask = 8'hFF;
      wr_val  = sfr_wdata_i;
    end else if (bit_wr_i) begin
      wr_mask[`TEC_T1_OVF_POS]  = bit_hit(bit_addr_i, `TEC_T1_OVF_POS);
      wr_mask[`TEC_T1_RUN_POS]  = bit_hit(bit_addr_i, `TEC_T1_RUN_POS);
      wr_mask[`TEC_T0_OVF_POS]  = bit_hit(bit_addr_i, `TEC_T0_OVF_POS);
      wr_mask[`TEC_T0_RUN_POS]  = bit_hit(bit_addr_i, `TEC_T0_RUN_POS);
      wr_mask[`TEC_X1_FLAG_POS] = bit_hit(bit_addr_i, `TEC_X1_FLAG_POS);
      wr_mask[`TEC_X1_TYPE_POS] = bit_hit(bit_addr_i, `TEC_X1_TYPE_POS);
      wr_mask[`TEC_X0_FLAG_POS] = bit_hit(bit_addr_i, `TEC_X0_FLAG_POS);
      wr_mask[`TEC_X0_TYPE_POS] = bit_hit(bit_addr_i, `TEC_X0_TYPE_POS);
      wr_val = {8{bit_wdata_i}};
    end
  end

  // ==================================================================
  // next-state of the register bits
  // hardware set beats both software clear and vector clear
  always @* begin
    // timer overflow flags
    if (t1_ovf_i) begin
      t1_overflow_flag_nxt = 1'h1;
    end else if (wr_mask[`TEC_T1_OVF_POS]) begin
      t1_overflow_flag_nxt = wr_val[`TEC_T1_OVF_POS];
    end else if (t1_vec_ack_i) begin
      t1_overflow_flag_nxt = 1'h0;
    end else begin
      t1_overflow_flag_nxt = t1_overflow_flag_r;
    end
    if (t0_ovf_i) begin
      t0_overflow_flag_nxt = 1'h1;
    end else if (wr_mask[`TEC_T0_OVF_POS]) begin
      t0_overflow_flag_nxt = wr_val[`TEC_T0_OVF_POS];
    end else if (t0_vec_ack_i) begin
      t0_overflow_flag_nxt = 1'h0;
    end else begin
      t0_overflow_flag_nxt = t0_overflow_flag_r;
    end
    // run bits are plain software storage
    t1_run_bit_nxt = wr_mask[`TEC_T1_RUN_POS] ?
                     wr_val[`TEC_T1_RUN_POS] : t1_run_bit_r;
    t0_run_bit_nxt = wr_mask[`TEC_T0_RUN_POS] ?
                     wr_val[`TEC_T0_RUN_POS] : t0_run_bit_r;
    // trigger types
    ext_req1_trigger_type_nxt = wr_mask[`TEC_X1_TYPE_POS] ?
                                wr_val[`TEC_X1_TYPE_POS] : ext_req1_trigger_type_r;
    ext_req0_trigger_type_nxt = wr_mask[`TEC_X0_TYPE_POS] ?
                                wr_val[`TEC_X0_TYPE_POS] : ext_req0_trigger_type_r;
    // request flags; level mode ignores writes since the pin owns the flag
    ext_req1_flag_nxt = req_next(ext_req1_trigger_type_r, ext_req1_flag_r,
                                 pin_b_fall, x1_vec_ack_i,
                                 wr_mask[`TEC_X1_FLAG_POS], wr_val[`TEC_X1_FLAG_POS],
                                 pin_b_lvl_r);
    ext_req0_flag_nxt = req_next(ext_req0_trigger_type_r, ext_req0_flag_r,
                                 pin_a_fall, x0_vec_ack_i,
                                 wr_mask[`TEC_X0_FLAG_POS], wr_val[`TEC_X0_FLAG_POS],
                                 pin_a_lvl_r);
  end

  // ==================================================================
  // register bits
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      t1_overflow_flag_r      <= reset_image[`TEC_T1_OVF_POS];
      t1_run_bit_r            <= reset_image[`TEC_T1_RUN_POS];
      t0_overflow_flag_r      <= reset_image[`TEC_T0_OVF_POS];
      t0_run_bit_r            <= reset_image[`TEC_T0_RUN_POS];
      ext_req1_flag_r         <= reset_image[`TEC_X1_FLAG_POS];
      ext_req1_trigger_type_r <= reset_image[`TEC_X1_TYPE_POS];
      ext_req0_flag_r         <= reset_image[`TEC_X0_FLAG_POS];
      ext_req0_trigger_type_r <= reset_image[`TEC_X0_TYPE_POS];
    end else begin
      t1_overflow_flag_r      <= t1_overflow_flag_nxt;
      t1_run_bit_r            <= t1_run_bit_nxt;
      t0_overflow_flag_r      <= t0_overflow_flag_nxt;
      t0_run_bit_r            <= t0_run_bit_nxt;
      ext_req1_flag_r         <= ext_req1_flag_nxt;
      ext_req1_trigger_type_r <= ext_req1_trigger_type_nxt;
      ext_req0_flag_r         <= ext_req0_flag_nxt;
      ext_req0_trigger_type_r <= ext_req0_trigger_type_nxt;
    end
  end

  // ==================================================================
  // outputs to timers and interrupt controller
  // count enables use only the run bits, gating and pin levels; of the low
  // nibble only the request flags reach irq_pend_o. one cycle behind the register image.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      t0_run_o      <= 1'h0;
      t1_run_o      <= 1'h0;
      t0_count_en_o <= 1'h0;
      t1_count_en_o <= 1'h0;
      irq_pend_o    <= 4'h0;
    end else begin
      t0_run_o      <= t0_run_bit_r;
      t1_run_o      <= t1_run_bit_r;
      t0_count_en_o <= t0_run_bit_r &
                       (~t0_pin_gating_bit_i | pin_a_lvl_r);
      t1_count_en_o <= t1_run_bit_r &
                       (~t1_pin_gating_bit_i | pin_b_lvl_r);
      irq_pend_o[`TEC_PEND_T0] <= t0_overflow_flag_r;
      irq_pend_o[`TEC_PEND_T1] <= t1_overflow_flag_r;
      irq_pend_o[`TEC_PEND_X0] <= ext_req0_flag_r;
      irq_pend_o[`TEC_PEND_X1] <= ext_req1_flag_r;
    end
  end

  // ==================================================================
  // read data
  // registered, so data follows the read strobe by one cycle; an access
  // to another address returns zero so the core can or-merge read buses
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
      bit_rdata_o <= 1'h0;
    end else begin
      if (sfr_rd_i && (sfr_addr_i == `TEC_SFR_ADDR)) begin
        sfr_rdata_o <= timer_and_extint_control;
      end else begin
        sfr_rdata_o <= 8'h00;
      end
      if (bit_rd_i && bit_hit(bit_addr_i, bit_addr_i[2:0])) begin
        bit_rdata_o <= timer_and_extint_control[bit_addr_i[2:0]];
      end else begin
        bit_rdata_o <= 1'h0;
      end
    end
  end

endmodule // tec_timer_extint_ctrl

`default_nettype wire
